// *** verilog/tsar_pkg.sv ***
// Constants, types and helpers for the temperature alarm readout
// Notes on behaviour
// - Conversions start by themselves right after reset, no command needed.
// - Each sample is a 9-bit two's complement code, half a degree per step.
// - Three address select pins give the low three bits of the slave address.
// - Latest temperature readable any time; every register reachable over serial link.
// - Over-limit and hysteresis limits are read/write registers, compared every sample.
// - Alarm pin works in comparator mode or interrupt mode, set by configuration.
// - Interrupt mode raises the alarm as an event when temperature exceeds the over-limit, then again when it falls below hysteresis.
// - Comparator mode acts as thermostat: set above over-limit, released below hysteresis.
// - Alarm pin is open drain: only pulled low, pull-up gives the high level.
// - Fault queue code 00/01/10/11 needs 1/2/4/6 consecutive hits before alarm changes.
// - Interrupt-mode alarm clears only on shutdown or on a register read.
// - Alarm polarity is a configuration bit, active low after reset.
// - Temperature sits in bits 15 to 7 of the 16-bit register, rest zero.
package tsar_pkg;
  // ==========================================================
  // Timing
  localparam int CORE_MHZ = 25;
  localparam int CONV_TIME_US = 150000;
  localparam int CONV_CYCLES = CONV_TIME_US * CORE_MHZ;
  localparam int SCL_MAX_KHZ = 400;
  localparam int FRAME_RST_NS = 200;
  localparam int FRAME_RST_CYC = FRAME_RST_NS * CORE_MHZ / 1000;
  localparam int CNT_W = 22;
  // ==========================================================
  // Serial protocol
  localparam logic [3:0] ADDR_BASE = 4'h9;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_OVER = 2'h3;
  // ==========================================================
  // Configuration fields and reset values
  localparam int CFG_SD = 0;
  localparam int CFG_INT = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_FQ_HI = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [8:0] OVER_RESET = 9'h0A0;
  localparam logic [8:0] HYST_RESET = 9'h096;
  localparam logic [8:0] TEMP_RESET = 9'h000;

  typedef enum logic [2:0] {
    LK_ADDR = 3'h0,
    LK_PTR = 3'h1,
    LK_WR = 3'h3,
    LK_RD = 3'h2,
    LK_IGN = 3'h4
  } tsar_link_t;

  // Consecutive hits needed for a fault queue code
  function automatic logic [2:0] tsar_fq_need(input logic [1:0] code);
    case (code)
      2'h0: tsar_fq_need = 3'h1;
      2'h1: tsar_fq_need = 3'h2;
      2'h2: tsar_fq_need = 3'h4;
      default: tsar_fq_need = 3'h6;
    endcase
  endfunction
endpackage

// *** verilog/tsar_top.sv ***
// Temperature readout with thermal alarm and serial slave port
`timescale 1ns/100ps
module tsar_top import tsar_pkg::*; #(
  parameter int CONV_CYC = CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic addr_sel_bit2,
  input wire logic [8:0] temp_code_in,
  output logic thermal_alarm_out,
  output logic thermal_alarm_out_oe
);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [2:0] HOLD_INIT = 3'(FRAME_RST_CYC);

  // ==========================================================
  // Core side: bus start/stop watch
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic idle_q, idle_d, frame_rst_q, frame_rst_d;
  logic [2:0] hold_q, hold_d;
  logic start_w, stop_w, link_rst_b;

  always_comb begin
    start_w = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    stop_w = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
    idle_d = stop_w ? 1'b1 : (start_w ? 1'b0 : idle_q);
    hold_d = start_w ? HOLD_INIT : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
    frame_rst_d = idle_d || (hold_d != 3'h0);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      idle_q <= 1'b1;
      hold_q <= 3'h0;
      frame_rst_q <= 1'b1;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_clk, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
      idle_q <= idle_d;
      hold_q <= hold_d;
      frame_rst_q <= frame_rst_d;
    end
  end

  // frame reset ends well inside the shortest legal clock low time
  assign link_rst_b = rst_b && !frame_rst_q;

  // ==========================================================
  // Core side: conversion and alarm
  logic cfg_t_s1_q, cfg_t_s2_q, cfg_t_s3_q, rd_t_s1_q, rd_t_s2_q, rd_t_s3_q;
  logic [4:0] cfg_c_q, cfg_c_d;
  logic [8:0] over_c_q, over_c_d, hyst_c_q, hyst_c_d, temp_q, temp_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d, temp_tgl_q, temp_tgl_d, seek_hot_q, seek_hot_d;
  logic int_pend_q, int_pend_d, alarm_oe_q, alarm_oe_d;
  logic [2:0] fcnt_q, fcnt_d, need;
  logic conv_end, over_w, under_w, hit, trip, rd_evt, act;
  // Link-side registers, declared here for the crossing
  logic [4:0] cfg_q;
  logic [8:0] over_q, hyst_q;
  logic cfg_tgl_q, rd_tgl_q;

  always_comb begin
    rd_evt = rd_t_s2_q ^ rd_t_s3_q;
    cfg_c_d = cfg_c_q;
    over_c_d = over_c_q;
    hyst_c_d = hyst_c_q;
    if (cfg_t_s2_q ^ cfg_t_s3_q) begin
      cfg_c_d = cfg_q;
      over_c_d = over_q;
      hyst_c_d = hyst_q;
    end
    conv_end = run_q && (cnt_q == CNT_LAST);
    // strict signed compare on nine bits
    over_w = $signed(temp_code_in) > $signed(over_c_q);
    under_w = $signed(temp_code_in) < $signed(hyst_c_q);
    hit = seek_hot_q ? over_w : under_w;
    need = tsar_fq_need(cfg_c_q[CFG_FQ_HI:CFG_FQ_LO]);
    trip = conv_end && hit && (fcnt_q + 3'h1 >= need);
    cnt_d = cnt_q;
    run_d = run_q;
    temp_d = temp_q;
    temp_tgl_d = temp_tgl_q;
    seek_hot_d = seek_hot_q;
    fcnt_d = fcnt_q;
    // free running converter, stops only after a shutdown request
    if (!run_q) begin
      cnt_d = '0;
      run_d = !cfg_c_q[CFG_SD];
    end else if (conv_end) begin
      cnt_d = '0;
      run_d = !cfg_c_q[CFG_SD];
      temp_d = temp_code_in;
      temp_tgl_d = !temp_tgl_q;
      if (!hit) begin
        fcnt_d = 3'h0;
      end else if (trip) begin
        fcnt_d = 3'h0;
        seek_hot_d = !seek_hot_q;
      end else begin
        fcnt_d = fcnt_q + 3'h1;
      end
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    // read or shutdown clears the event
    int_pend_d = int_pend_q;
    if (rd_evt || cfg_c_q[CFG_SD]) begin
      int_pend_d = 1'b0;
    end
    // a trip in interrupt mode sets the event, winning over a clear
    if (trip && cfg_c_q[CFG_INT]) begin
      int_pend_d = 1'b1;
    end
    // mode select; thermostat follows the hot/cold state
    act = cfg_c_q[CFG_INT] ? int_pend_d : !seek_hot_d;
    // polarity bit, zero means pull low while active
    alarm_oe_d = act ^ cfg_c_q[CFG_POL];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {cfg_t_s1_q, cfg_t_s2_q, cfg_t_s3_q} <= 3'h0;
      {rd_t_s1_q, rd_t_s2_q, rd_t_s3_q} <= 3'h0;
      cfg_c_q <= CFG_RESET;
      over_c_q <= OVER_RESET;
      hyst_c_q <= HYST_RESET;
      cnt_q <= '0;
      run_q <= 1'b1;
      temp_q <= TEMP_RESET;
      temp_tgl_q <= 1'b0;
      seek_hot_q <= 1'b1;
      fcnt_q <= 3'h0;
      int_pend_q <= 1'b0;
      alarm_oe_q <= 1'b0;
    end else begin
      {cfg_t_s1_q, cfg_t_s2_q, cfg_t_s3_q} <= {cfg_tgl_q, cfg_t_s1_q, cfg_t_s2_q};
      {rd_t_s1_q, rd_t_s2_q, rd_t_s3_q} <= {rd_tgl_q, rd_t_s1_q, rd_t_s2_q};
      cfg_c_q <= cfg_c_d;
      over_c_q <= over_c_d;
      hyst_c_q <= hyst_c_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      temp_q <= temp_d;
      temp_tgl_q <= temp_tgl_d;
      seek_hot_q <= seek_hot_d;
      fcnt_q <= fcnt_d;
      int_pend_q <= int_pend_d;
      alarm_oe_q <= alarm_oe_d;
    end
  end

  // open drain, only ever pulls low
  assign thermal_alarm_out = 1'b0;
  assign thermal_alarm_out_oe = alarm_oe_q;

  // ==========================================================
  // Link side: serial slave on the bus clock
  tsar_link_t phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [6:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d, hi_q, hi_d, byte_w;
  logic ack_q, ack_d, idx_q, idx_d, sda_oe_q, sda_oe_d;
  logic [1:0] ptr_q, ptr_d;
  logic [2:0] a_s1_q, a_s2_q;
  logic tt_s1_q, tt_s2_q, tt_s3_q;
  logic [8:0] temp_lk_q, temp_lk_d, over_d, hyst_d;
  logic [4:0] cfg_d;
  logic cfg_tgl_d, rd_tgl_d, addr_ok, wr_cfg, wr_lim, ptr_wr, rd_start;

  // Byte presented for a pointer and byte index
  function automatic logic [7:0] tx_pick(input logic [1:0] ptr, input logic idx);
    case (ptr)
      // sample in the top nine bits, low bits zero
      PTR_TEMP: tx_pick = idx ? {temp_lk_q[0], 7'h00} : temp_lk_q[8:1];
      PTR_CFG: tx_pick = {3'h0, cfg_q};
      PTR_HYST: tx_pick = idx ? {hyst_q[0], 7'h00} : hyst_q[8:1];
      default: tx_pick = idx ? {over_q[0], 7'h00} : over_q[8:1];
    endcase
  endfunction

  always_comb begin
    byte_w = {shift_q, sda_in};
    // low address bits from the select pins
    addr_ok = byte_w[7:1] == {ADDR_BASE, a_s2_q};
    phase_d = phase_q;
    bit_d = bit_q;
    shift_d = shift_q;
    tx_d = tx_q;
    hi_d = hi_q;
    ack_d = ack_q;
    idx_d = idx_q;
    wr_cfg = 1'b0;
    wr_lim = 1'b0;
    ptr_wr = 1'b0;
    rd_start = 1'b0;
    if (bit_q == BIT_ACK) begin
      bit_d = 4'h0;
      ack_d = 1'b0;
      if (phase_q == LK_RD && !ack_q) begin
        if (sda_in) begin
          phase_d = LK_IGN;
        end else begin
          idx_d = !idx_q;
          tx_d = tx_pick(ptr_q, !idx_q);
        end
      end
    end else begin
      bit_d = bit_q + 4'h1;
      shift_d = byte_w[6:0];
      if (bit_q == BIT_LAST) begin
        case (phase_q)
          LK_ADDR: begin
            if (addr_ok) begin
              ack_d = 1'b1;
              idx_d = 1'b0;
              phase_d = byte_w[0] ? LK_RD : LK_PTR;
              // read starts from the stored pointer
              tx_d = tx_pick(ptr_q, 1'b0);
              rd_start = byte_w[0];
            end else begin
              phase_d = LK_IGN;
            end
          end
          LK_PTR: begin
            ack_d = 1'b1;
            ptr_wr = 1'b1;
            idx_d = 1'b0;
            phase_d = LK_WR;
          end
          LK_WR: begin
            ack_d = 1'b1;
            if (ptr_q == PTR_CFG) begin
              wr_cfg = 1'b1;
            end else if (ptr_q != PTR_TEMP) begin
              hi_d = idx_q ? hi_q : byte_w;
              wr_lim = idx_q;
              idx_d = !idx_q;
            end
          end
          default: ack_d = 1'b0;
        endcase
      end
    end
    // drive acknowledge or read data on the falling edge
    sda_oe_d = (bit_q == BIT_ACK) ? ack_q : (phase_q == LK_RD && !tx_q[~bit_q[2:0]]);
    ptr_d = ptr_wr ? byte_w[1:0] : ptr_q;
    cfg_d = wr_cfg ? byte_w[4:0] : cfg_q;
    over_d = (wr_lim && ptr_q == PTR_OVER) ? {hi_q, byte_w[7]} : over_q;
    hyst_d = (wr_lim && ptr_q == PTR_HYST) ? {hi_q, byte_w[7]} : hyst_q;
    cfg_tgl_d = cfg_tgl_q ^ (wr_cfg || wr_lim);
    // every read transfer is reported to the alarm logic
    rd_tgl_d = rd_tgl_q ^ rd_start;
    temp_lk_d = (tt_s2_q ^ tt_s3_q) ? temp_q : temp_lk_q;
  end

  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      phase_q <= LK_ADDR;
      bit_q <= 4'h0;
      shift_q <= 7'h00;
      tx_q <= 8'hFF;
      hi_q <= 8'h00;
      ack_q <= 1'b0;
      idx_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      hi_q <= hi_d;
      ack_q <= ack_d;
      idx_q <= idx_d;
    end
  end

  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_s1_q <= 3'h0;
      a_s2_q <= 3'h0;
      {tt_s1_q, tt_s2_q, tt_s3_q} <= 3'h0;
      temp_lk_q <= TEMP_RESET;
      ptr_q <= PTR_TEMP;
      cfg_q <= CFG_RESET;
      over_q <= OVER_RESET;
      hyst_q <= HYST_RESET;
      cfg_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else begin
      a_s1_q <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
      a_s2_q <= a_s1_q;
      {tt_s1_q, tt_s2_q, tt_s3_q} <= {temp_tgl_q, tt_s1_q, tt_s2_q};
      temp_lk_q <= temp_lk_d;
      ptr_q <= ptr_d;
      cfg_q <= cfg_d;
      over_q <= over_d;
      hyst_q <= hyst_d;
      cfg_tgl_q <= cfg_tgl_d;
      rd_tgl_q <= rd_tgl_d;
    end
  end

  always_ff @(negedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= sda_oe_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;

  // ==========================================================
  // Assertions
  a_conv_sample: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_end |=> (temp_q == $past(temp_code_in))) else $error("sample not captured");
  a_conv_running: assert property (@(posedge core_clk) disable iff (!rst_b)
    !cfg_c_q[CFG_SD] |=> run_q) else $error("converter not running");
  a_eval_only: assert property (@(posedge core_clk) disable iff (!rst_b)
    !conv_end |=> ($stable(seek_hot_q) && $stable(fcnt_q) && !$rose(int_pend_q)))
    else $error("alarm state moved between conversions");
  a_fault_trip: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(seek_hot_q) |-> ($past(conv_end) && ($past(fcnt_q) + 3'h1 == $past(need))))
    else $error("fault queue count wrong");
  a_strict_over: assert property (@(posedge core_clk) disable iff (!rst_b)
    (conv_end && seek_hot_q && temp_code_in == over_c_q) |=> (fcnt_q == 3'h0))
    else $error("equal counted as over");
  a_int_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (int_pend_q && rd_evt && !conv_end) |=> !int_pend_q) else $error("read did not clear");
  a_cmp_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!cfg_c_q[CFG_INT] && !cfg_c_q[CFG_POL]) ##1 $stable(cfg_c_q)
    |-> (thermal_alarm_out_oe == !seek_hot_q)) else $error("thermostat level wrong");
  a_addr_ack: assert property (@(posedge scl_clk) disable iff (!link_rst_b)
    (bit_q == BIT_LAST && phase_q == LK_ADDR && addr_ok) |=> (ack_q && phase_q != LK_IGN))
    else $error("own address not acked");
  a_ack_drive: assert property (@(posedge scl_clk) disable iff (!link_rst_b)
    (bit_q == BIT_ACK && ack_q) |-> sda_oe_q) else $error("ack not driven");
  a_limit_write: assert property (@(posedge scl_clk) disable iff (!link_rst_b)
    (bit_q == BIT_LAST && phase_q == LK_WR && ptr_q == PTR_OVER && idx_q)
    |=> (over_q == {$past(hi_q), $past(shift_q[6])})) else $error("limit write lost");
endmodule

// *** test/tsar_i2c_master.sv ***
// Serial bus master model for the temperature alarm readout
`timescale 1ns/100ps
module tsar_i2c_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ==========================================================
  // Bus timing
  // Quarter bit; four of them make one bit
  localparam time QTR = 625;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // Also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic get(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!more, r);
  endtask
endmodule

// *** test/tsar_test.sv ***
// Self-checking bench for the temperature alarm readout
`timescale 1ns/100ps
module tsar_test import tsar_pkg::*; ;
  localparam int CONV = 50;
  localparam int LIMIT = 95000;
  localparam int NEED [4] = '{1, 2, 4, 6};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [8:0] temp_code = 9'h000;
  logic [6:0] dev;
  wire scl;
  wire m_low;
  wire sda_out;
  wire sda_oe;
  wire alarm_out;
  wire alarm_oe;
  wire sda_w;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  // Open-drain wire with pull-up
  assign sda_w = !(m_low | (sda_oe & !sda_out));
  assign dev = {ADDR_BASE, straps};
  always #20 core_clk = ~core_clk;

  tsar_i2c_master u_master (.scl(scl), .sda_low(m_low), .sda(sda_w));
  tsar_top #(.CONV_CYC(CONV)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .scl_clk(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_bit0(straps[0]),
    .addr_sel_bit1(straps[1]), .addr_sel_bit2(straps[2]), .temp_code_in(temp_code),
    .thermal_alarm_out(alarm_out), .thermal_alarm_out_oe(alarm_oe)
  );

  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic set_temp(input logic [8:0] v);
    wait_cyc(1);
    temp_code = v;
  endtask

  task automatic xfer(input logic [6:0] a7, input logic wp, input logic [1:0] ptr,
      input int nwr, input logic [15:0] wd, input int nrd, output logic [15:0] rd,
      output logic ack);
    logic a;
    logic [7:0] b;
    rd = 16'h0000;
    ack = 1'b1;
    if (wp) begin
      u_master.start();
      u_master.put({a7, 1'b0}, a);
      ack &= a;
      u_master.put({6'h00, ptr}, a);
      for (int i = 0; i < nwr; i++) begin
        u_master.put(wd[15 - 8 * i -: 8], a);
      end
    end
    if (nrd > 0) begin
      u_master.start();
      u_master.put({a7, 1'b1}, a);
      ack &= a;
      for (int i = 0; i < nrd; i++) begin
        u_master.get(i < nrd - 1, b);
        rd[15 - 8 * i -: 8] = b;
      end
    end
    u_master.stop();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_address();
    logic [15:0] rd;
    logic ack;
    set_temp(9'h1CE);
    wait_cyc(4 * CONV);
    for (int s = 0; s < 8; s++) begin
      straps = 3'(s);
      wait_cyc(2);
      xfer(dev, 1'b0, PTR_TEMP, 0, 16'h0000, 2, rd, ack);
      chk(16'(ack), 16'h0001);
      chk(rd, 16'hE700);
    end
    xfer({ADDR_BASE, 3'h2}, 1'b0, PTR_TEMP, 0, 16'h0000, 2, rd, ack);
    chk(16'(ack), 16'h0000);
  endtask

  task automatic t_limits();
    logic [15:0] rd;
    logic ack;
    xfer(dev, 1'b1, PTR_HYST, 0, 16'h0000, 2, rd, ack);
    chk(rd, 16'h4B00);
    xfer(dev, 1'b1, PTR_OVER, 2, 16'hFF80, 2, rd, ack);
    chk(rd, 16'hFF80);
    xfer(dev, 1'b1, PTR_OVER, 2, 16'h5000, 2, rd, ack);
    chk(rd, 16'h5000);
    xfer(dev, 1'b1, PTR_HYST, 2, 16'hC980, 2, rd, ack);
    chk(rd, 16'hC980);
    xfer(dev, 1'b1, PTR_HYST, 2, 16'h4B00, 2, rd, ack);
    chk(rd, 16'h4B00);
    xfer(dev, 1'b1, PTR_TEMP, 2, 16'h1234, 2, rd, ack);
    chk(rd, 16'hE700);
  endtask

  task automatic t_comparator();
    logic [15:0] rd;
    logic ack;
    for (int c = 0; c < 4; c++) begin
      set_temp(9'h000);
      xfer(dev, 1'b1, PTR_CFG, 1, {3'h0, 2'(c), 3'h0, 8'h00}, 0, rd, ack);
      set_temp(9'h0A0);
      wait_cyc(8 * CONV);
      chk(16'(alarm_oe), 16'h0000);
      set_temp(9'h0A1);
      if (NEED[c] > 1) begin
        wait_cyc((NEED[c] - 1) * CONV - 10);
        chk(16'(alarm_oe), 16'h0000);
      end
      wait_cyc(2 * CONV + 20);
      chk(16'(alarm_oe), 16'h0001);
    end
    set_temp(9'h096);
    wait_cyc(10 * CONV);
    chk(16'(alarm_oe), 16'h0001);
    set_temp(9'h095);
    wait_cyc(8 * CONV);
    chk(16'(alarm_oe), 16'h0000);
  endtask

  task automatic t_interrupt();
    logic [15:0] rd;
    logic ack;
    xfer(dev, 1'b1, PTR_CFG, 1, 16'h0200, 0, rd, ack);
    wait_cyc(2 * CONV);
    chk(16'(alarm_oe), 16'h0000);
    set_temp(9'h0A1);
    wait_cyc(2 * CONV);
    chk(16'(alarm_oe), 16'h0001);
    wait_cyc(6 * CONV);
    chk(16'(alarm_oe), 16'h0001);
    xfer(dev, 1'b1, PTR_TEMP, 0, 16'h0000, 2, rd, ack);
    chk(rd, 16'h5080);
    chk(16'(alarm_oe), 16'h0000);
    set_temp(9'h000);
    wait_cyc(2 * CONV);
    chk(16'(alarm_oe), 16'h0001);
    xfer(dev, 1'b1, PTR_CFG, 1, 16'h0300, 0, rd, ack);
    wait_cyc(5);
    chk(16'(alarm_oe), 16'h0000);
  endtask

  task automatic t_polarity();
    logic [15:0] rd;
    logic ack;
    xfer(dev, 1'b1, PTR_CFG, 1, 16'h0400, 1, rd, ack);
    chk(rd, 16'h0400);
    wait_cyc(2 * CONV);
    chk(16'(alarm_oe), 16'h0001);
    set_temp(9'h0A1);
    wait_cyc(3 * CONV);
    chk(16'(alarm_oe), 16'h0000);
    chk(16'(alarm_out), 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    wait_cyc(5);
    chk({13'h0000, sda_out, sda_oe, alarm_oe}, 16'h0000);
    t_address();
    t_limits();
    t_comparator();
    t_interrupt();
    t_polarity();
    summarize();
  end
endmodule
